/* dfic_combiner.sv */
// top of the dual function interrupt combiner
`include "dfic_consts.svh"
module dfic_combiner (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // card functions
    input wire logic [1:0] function_irq_in_i,
    input dfic_pkg::dfic_func_cfg_s [1:0] function_status_reg_i,
    // status back to host side
    output dfic_pkg::dfic_func_stat_s [1:0] function_status_reg_o,
    // host interrupt line, active low
    output logic host_irq_n_o
);
    import dfic_pkg::*;

    typedef struct packed {
        dfic_state_e state;
        logic [1:0] pending;
        logic [1:0] held;
        logic [1:0] prev_in;
        logic irq;
        logic start;
        logic irq_n;
        dfic_func_stat_s [1:0] stat;
    } dfic_top_s;

    dfic_top_s st;
    dfic_top_s next_st;
    logic timer_busy;
    logic enh;
    logic pulse;
    logic pend_clr;
    logic [1:0] rise;

    dfic_pulse_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .start_i(st.start),
        .busy_o(timer_busy)
    );

    // ************************************************************
    // decode helpers
    // ************************************************************
    // either function may switch the shared line into enhanced handling
    function automatic logic any_enhanced(input dfic_func_cfg_s [1:0] cfg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `DFIC_NUM_FUNC; i++) begin
            hit = hit | cfg[i].enhanced_irq_select;
        end
        return hit;
    endfunction

    // one shared line, so one pulse or level choice for both functions
    function automatic logic any_pulse(input dfic_func_cfg_s [1:0] cfg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `DFIC_NUM_FUNC; i++) begin
            hit = hit | cfg[i].pulse_mode;
        end
        return hit;
    endfunction

    // a zero written to the pending flag of either function acknowledges
    function automatic logic any_zero_write(input dfic_func_cfg_s [1:0] cfg);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < `DFIC_NUM_FUNC; i++) begin
            hit = hit | (cfg[i].pending_wr & ~cfg[i].pending_wdata);
        end
        return hit;
    endfunction

    function automatic logic [1:0] rising(input logic [1:0] cur, input logic [1:0] prev);
        return cur & ~prev;
    endfunction

    // ************************************************************
    // mode decode
    // ************************************************************
    // function 0 alone governs in single-function use; either select turns enhanced on
    assign enh = any_enhanced(function_status_reg_i);
    assign pulse = any_pulse(function_status_reg_i);
    assign pend_clr = any_zero_write(function_status_reg_i);
    assign rise = rising(function_irq_in_i, st.prev_in);

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        next_st = st;
        next_st.start = 1'b0;
        next_st.prev_in = function_irq_in_i;
        // new requests are latched in enhanced mode; there set wins over any clear in the same cycle
        next_st.held = st.held | rise;
        if (!enh) begin
            next_st.state = DFIC_IDLE;
            next_st.pending = 2'b00;
            next_st.held = 2'b00;
            if (pulse) begin
                // re-pulse on each new edge of the or
                if ((|function_irq_in_i) && !(|st.prev_in)) begin
                    next_st.start = 1'b1;
                end
                // the start cycle is not counted, so the line is low for exactly the timer span
                next_st.irq = timer_busy;
            end else begin
                next_st.irq = |function_irq_in_i;
            end
        end else begin
            unique case (st.state)
                DFIC_IDLE: begin
                    next_st.irq = 1'b0;
                    // a still-asserted level also counts as pending
                    if (|(st.held | function_irq_in_i)) begin
                        next_st.pending = st.held | function_irq_in_i;
                        next_st.held = rise;
                        if (pulse) begin
                            next_st.start = 1'b1;
                            next_st.state = DFIC_PULSE;
                        end else begin
                            next_st.irq = 1'b1;
                            next_st.state = DFIC_LEVEL;
                        end
                    end
                end
                DFIC_PULSE: begin
                    next_st.irq = timer_busy;
                    if (!timer_busy && !st.start) begin
                        next_st.irq = 1'b0;
                        next_st.state = DFIC_WAIT_CLR;
                    end
                    if (pend_clr) begin
                        next_st.state = DFIC_WAIT_CLR;
                    end
                end
                DFIC_LEVEL: begin
                    next_st.irq = 1'b1;
                    if (pend_clr) begin
                        next_st.irq = 1'b0;
                        next_st.pending = 2'b00;
                        next_st.state = DFIC_IDLE;
                    end
                end
                DFIC_WAIT_CLR: begin
                    // line finishes any running pulse, then stays quiet until the handler acknowledges
                    next_st.irq = timer_busy;
                    if (pend_clr && !timer_busy) begin
                        next_st.pending = 2'b00;
                        next_st.state = DFIC_IDLE;
                    end
                end
            endcase
        end
        next_st.irq_n = ~next_st.irq;
        for (int i = 0; i < `DFIC_NUM_FUNC; i++) begin
            next_st.stat[i].pending = enh ? next_st.pending[i] : function_irq_in_i[i];
            next_st.stat[i].held = next_st.held[i];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st <= '0;
            st.state <= DFIC_IDLE;
            st.irq_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign host_irq_n_o = st.irq_n;
    assign function_status_reg_o = st.stat;
endmodule

/* dfic_combiner_monitor.sv */
// port checker of the interrupt combiner
module dfic_combiner_monitor (
    input logic clk_sys_i,
    input logic srst_i,
    input logic [1:0] function_irq_in_i,
    input dfic_pkg::dfic_func_cfg_s [1:0] function_status_reg_i,
    input dfic_pkg::dfic_func_stat_s [1:0] function_status_reg_o,
    input logic host_irq_n_o
);
    import dfic_pkg::*;
    dfic_func_cfg_s [1:0] c;
    logic enh, pls, clr, lvl;
    logic [4:0] low_cnt;
    assign c = function_status_reg_i;
    assign enh = c[0].enhanced_irq_select | c[1].enhanced_irq_select;
    assign pls = c[0].pulse_mode | c[1].pulse_mode;
    assign clr = |{c[0].pending_wr & ~c[0].pending_wdata, c[1].pending_wr & ~c[1].pending_wdata};
    assign lvl = enh & ~pls & ~host_irq_n_o;
    // saturates so a stuck line cannot wrap back into range
    always_ff @(posedge clk_sys_i) begin
        if (srst_i || host_irq_n_o) begin
            low_cnt <= 5'h00;
        end else if (low_cnt != 5'h1F) begin
            low_cnt <= low_cnt + 5'h01;
        end
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_plain_on: assert property (!enh && !pls && |function_irq_in_i |=> !host_irq_n_o)
        else $error("plain request not passed");
    a_plain_off: assert property (!enh && !pls && !function_irq_in_i |=> host_irq_n_o)
        else $error("plain line not released");
    a_pulse_width: assert property (pls && $rose(host_irq_n_o) |-> low_cnt == 5'h10)
        else $error("pulse width wrong");
    a_enh_hold: assert property (lvl && !clr |=> !host_irq_n_o)
        else $error("enhanced line dropped early");
    a_enh_release: assert property (lvl && clr |=> host_irq_n_o)
        else $error("enhanced line not released");
    a_enh_rearm: assert property (lvl && clr && |function_irq_in_i |=> host_irq_n_o ##[1:3] !host_irq_n_o)
        else $error("pending request lost");
    a_pending_source:
        assert property (enh && $fell(host_irq_n_o) |-> |{function_status_reg_o[0].pending,
            function_status_reg_o[1].pending}) else $error("no source flagged");
    a_held_capture:
        assert property (lvl && !clr && !$past(host_irq_n_o) && $rose(function_irq_in_i[1]) |->
            ##[0:2] function_status_reg_o[1].held) else $error("late request not held");
endmodule

/* dfic_consts.svh */
// constants of the dual function interrupt combiner
// Function
// - host request is plain or of both functions, or enhanced handshake per select bit
// - enhanced mode sequences requests so the host controller never misses one
// - pulse or level signalling selectable in both plain and enhanced mode
// - in enhanced mode, after pending clear (in pulse mode, written after the pulse), a further pending request raises a new host interrupt
// - in plain level mode, host request asserts whenever either function request is asserted
// - each host pulse lasts sixteen master clock periods, longer in plain mode when a new edge restarts the running timer
`ifndef DFIC_CONSTS_SVH
`define DFIC_CONSTS_SVH

// ************************************************************
// timing
// ************************************************************
`define DFIC_PULSE_CYCLES 16
`define DFIC_PULSE_CNT_W 5

// ************************************************************
// reset values and number of functions
// ************************************************************
`define DFIC_RST_ENH 1'b0
`define DFIC_RST_PULSE 1'b0
`define DFIC_RST_PENDING 1'b0
`define DFIC_NUM_FUNC 2

`endif

/* dfic_host_model.sv */
// host model: services the line, then writes zero to the pending flag
module dfic_host_model #(
    parameter int SERVICE_CYCLES = 20
) (
    input logic clk_sys_i,
    input logic srst_i,
    input logic host_irq_n_i,
    output logic clear_o
);
    int cnt;
    // counting starts at the fall, so a whole pulse has ended before the write
    always_ff @(posedge clk_sys_i) begin
        clear_o <= 1'b0;
        if (srst_i || (cnt == 0 && host_irq_n_i)) begin
            cnt <= 0;
        end else if (cnt == SERVICE_CYCLES) begin
            cnt <= 0;
            clear_o <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* dfic_pkg.sv */
// types of the dual function interrupt combiner
package dfic_pkg;
    typedef enum logic [1:0] {
        DFIC_IDLE,
        DFIC_PULSE,
        DFIC_LEVEL,
        DFIC_WAIT_CLR
    } dfic_state_e;

    // per-function configuration and status write
    typedef struct packed {
        logic enhanced_irq_select;
        logic pulse_mode;
        logic pending_wr;
        logic pending_wdata;
    } dfic_func_cfg_s;

    typedef struct packed {
        logic pending;
        logic held;
    } dfic_func_stat_s;
endpackage

/* dfic_pulse_timer.sv */
// pulse width timer for the host interrupt line
`include "dfic_consts.svh"
module dfic_pulse_timer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // control
    input wire logic start_i,
    output logic busy_o
);
    import dfic_pkg::*;

    typedef struct packed {
        logic [`DFIC_PULSE_CNT_W-1:0] cnt;
        logic busy;
    } dfic_timer_s;

    dfic_timer_s st;
    dfic_timer_s next_st;

    always_comb begin
        next_st = st;
        if (start_i) begin
            next_st.cnt = `DFIC_PULSE_CNT_W'(`DFIC_PULSE_CYCLES - 1);
            next_st.busy = 1'b1;
        end else if (st.busy) begin
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busy_o = st.busy;
endmodule

/* tb.sv */
// testbench of the dual function interrupt combiner
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dfic_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic [1:0] irq_in = 2'b00;
    logic enh = 1'b0;
    logic pls = 1'b0;
    logic clear;
    logic host_irq_n;
    dfic_func_cfg_s [1:0] cfg;
    dfic_func_stat_s [1:0] stat;
    int n_fail = 0;
    int total_checks = 0;
    assign cfg[0] = {enh, pls, clear & enh, 1'b0};
    assign cfg[1] = {enh, pls, 1'b0, 1'b0};
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    dfic_combiner u_dfic_combiner (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .function_irq_in_i(irq_in),
        .function_status_reg_i(cfg), .function_status_reg_o(stat), .host_irq_n_o(host_irq_n));
    dfic_host_model u_dfic_host_model (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .host_irq_n_i(host_irq_n),
        .clear_o(clear));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic tick();
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wait_lvl(input logic v, output int n);
        n = 0;
        do begin
            tick();
            n++;
        end while (host_irq_n !== v && n < 100);
    endtask
    task automatic start(input logic e, input logic p);
        @(posedge clk_sys_i);
        srst_i <= 1'b1;
        irq_in <= 2'b00;
        enh <= e;
        pls <= p;
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        tick();
        chk({host_irq_n, stat}, 8'h10);
    endtask
    task automatic t_plain_level();
        start(1'b0, 1'b0);
        @(posedge clk_sys_i);
        irq_in <= 2'b10;
        repeat (2) tick();
        chk(host_irq_n, 1'b0);
        @(posedge clk_sys_i);
        irq_in <= 2'b00;
        repeat (2) tick();
        chk(host_irq_n, 1'b1);
    endtask
    // plain mode must not pulse again; enhanced mode must, for the held request
    task automatic t_pulse(input logic e);
        int n;
        int w;
        start(e, 1'b1);
        @(posedge clk_sys_i);
        irq_in <= 2'b01;
        wait_lvl(1'b0, n);
        irq_in <= 2'b11;
        wait_lvl(1'b1, w);
        chk(w == 16, 1'b1);
        wait_lvl(1'b0, n);
        chk(n < 60, e);
    endtask
    task automatic t_enh_level();
        int n;
        start(1'b1, 1'b0);
        @(posedge clk_sys_i);
        irq_in <= 2'b01;
        wait_lvl(1'b0, n);
        chk(stat[0].pending, 1'b1);
        @(posedge clk_sys_i);
        irq_in <= 2'b10;
        repeat (3) tick();
        chk({host_irq_n, stat[1].held}, 2'b01);
        wait_lvl(1'b1, n);
        chk(n > 10 && n < 40, 1'b1);
        wait_lvl(1'b0, n);
        chk({n < 4, stat[1].pending}, 2'b11);
    endtask
    initial begin
        t_plain_level();
        t_pulse(1'b0);
        t_pulse(1'b1);
        t_enh_level();
        wrap_up();
    end
    initial begin
        #80000;
        n_fail++;
        wrap_up();
    end
endmodule
bind dfic_combiner dfic_combiner_monitor u_dfic_combiner_monitor (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .function_irq_in_i(function_irq_in_i), .function_status_reg_i(function_status_reg_i),
    .function_status_reg_o(function_status_reg_o), .host_irq_n_o(host_irq_n_o));
